// [logic/ssac_params.svh]
// timing, width and encoding constants of the serial conversion controller
`ifndef SSAC_PARAMS_SVH
`define SSAC_PARAMS_SVH
`define SSAC_RES_BITS 6
`define SSAC_FULL_CODE 6'h3f
`define SSAC_MSB_IDX 5
`define SSAC_SYS_PERIOD_NS 8
`define SSAC_START_HIGH_NS 500
`define SSAC_START_HIGH_CYC ((`SSAC_START_HIGH_NS + `SSAC_SYS_PERIOD_NS - 1) / `SSAC_SYS_PERIOD_NS)
`define SSAC_CONV_CLOCKS 8
`endif

// [logic/ssac_pkg.sv]
// types shared by the serial conversion controller
package ssac_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM = 4'h2,
    ST_TRIAL = 4'h4,
    ST_HOLD = 4'h8
  } ssac_state_t;
  // one decided bit and its position
  typedef struct packed {
    logic bit_val;
    logic [2:0] bit_idx;
  } ssac_bit_t;
endpackage

// [logic/ssac_skid.sv]
// two-entry valid/ready buffer for decided bits
`timescale 1ns/1ps
module ssac_skid
  import ssac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire ssac_bit_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output ssac_bit_t out_data_o
);
  ssac_bit_t mem_ff [2];
  logic [1:0] cnt_ff;
  logic rd_ff;
  logic wr_ff;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // honest full and empty flags
  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ff];
  // pointer and count update
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_ff <= 2'h0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end
    else if (flush_i)
    begin
      cnt_ff <= 2'h0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      if (push)
        wr_ff <= ~wr_ff;
      if (pop)
        rd_ff <= ~rd_ff;
    end
  end
  // storage write
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data_i;
  end
  a_skid_no_over: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cnt_ff <= 2'h2) else $error("buffer count overflow");
endmodule // ssac_skid

// [logic/ssac_top.sv]
// serial successive-approximation conversion control
`timescale 1ns/1ps
`include "ssac_params.svh"
// How it works
// RULE_01 - six-bit result leaves one bit at a time on one serial pin
// RULE_02 - host supplies conversion clock, at most 350 kHz
// RULE_03 - sequence starts on first falling clock edge after start goes low
// RULE_04 - bits are decided from result_msb downward
// RULE_05 - trial above input clears bit and shows 0, else keeps 1
// RULE_06 - result_msb is valid after second falling clock edge after start
// RULE_07 - each further clock pulse tries and shows the next lower bit
// RULE_08 - host keeps start low at least 8 clock pulses
// RULE_09 - a new start pulse aborts and restarts from result_msb
// RULE_10 - start high puts serial output in high impedance
// RULE_11 - host holds start high at least 500 ns between conversions
// RULE_12 - input above full scale yields all-ones code
// RULE_13 - last bit stays on the output until start returns high
module ssac_top
  import ssac_pkg::*;
#(
  parameter int RES_BITS = `SSAC_RES_BITS
)
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic START_B_I,
  input wire logic CONV_CLK_I,
  input wire logic CMP_HIGH_I,
  output logic [RES_BITS-1:0] TRIAL_CODE_O,
  output logic [RES_BITS-1:0] RESULT_O,
  output logic DONE_O,
  output logic SDATA_O,
  output logic SDATA_OE_B_O
);
  // refuse widths that the sequencer and its three-bit index cannot serve
  if (RES_BITS != `SSAC_RES_BITS)
  begin : g_bad_width
    $error("only six result bits are supported");
  end

  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_b;
  logic [1:0] start_sync_ff;
  logic [1:0] cclk_sync_ff;
  logic [1:0] cmp_sync_ff;
  logic cclk_prev_ff;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_b = rst_sync_ff[1];

  // two flops per pin; only the second stage is read
  always_ff @(posedge CLK_SYS_I or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_sync_ff <= 2'h3;
      cclk_sync_ff <= 2'h0;
      cmp_sync_ff <= 2'h0;
      cclk_prev_ff <= 1'b0;
    end
    else
    begin
      start_sync_ff <= {start_sync_ff[0], START_B_I};
      cclk_sync_ff <= {cclk_sync_ff[0], CONV_CLK_I};
      cmp_sync_ff <= {cmp_sync_ff[0], CMP_HIGH_I};
      cclk_prev_ff <= cclk_sync_ff[1];
    end
  end

  // ------------------------------------------------------------
  // event decoding
  // ------------------------------------------------------------
  logic start_low_ff;
  wire start_low = ~start_sync_ff[1];
  wire start_fall = start_low && !start_low_ff;
  wire cclk_fall = cclk_prev_ff && !cclk_sync_ff[1];
  wire cmp_high = cmp_sync_ff[1];

  // one-hot trial mask for a bit position
  function automatic logic [RES_BITS-1:0] bit_mask(input logic [2:0] idx);
    bit_mask = RES_BITS'(1) << idx;
  endfunction

  // ------------------------------------------------------------
  // approximation sequencer
  // ------------------------------------------------------------
  ssac_state_t state_ff;
  ssac_state_t nxt_state;
  logic [RES_BITS-1:0] approximation_register_ff;
  logic [RES_BITS-1:0] nxt_approx;
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic push_valid;
  logic push_ready;
  ssac_bit_t push_data;

  // decide: trial above input clears the bit, else it stays set
  wire [RES_BITS-1:0] cur_mask = bit_mask(idx_ff);
  wire decided = !cmp_high; // RULE_05
  wire [RES_BITS-1:0] kept = decided ? approximation_register_ff
                                     : (approximation_register_ff & ~cur_mask); // RULE_05
  wire [RES_BITS-1:0] next_trial = (idx_ff == 3'h0) ? kept : (kept | bit_mask(idx_ff - 3'h1));
  // a decision waits if the buffer is full; it is taken on a later edge
  wire trial_go = cclk_fall && push_ready;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_approx = approximation_register_ff;
    nxt_idx = idx_ff;
    push_valid = 1'b0;
    push_data = '{bit_val: decided, bit_idx: idx_ff};
    case (state_ff)
      ST_IDLE:
      begin
        if (start_low)
        begin
          nxt_state = ST_ARM;
          nxt_approx = bit_mask(3'(`SSAC_MSB_IDX)); // RULE_04
          nxt_idx = 3'(`SSAC_MSB_IDX);
        end
      end
      ST_ARM:
      begin
        if (cclk_fall)
          nxt_state = ST_TRIAL; // RULE_03
      end
      ST_TRIAL:
      begin
        if (trial_go)
        begin
          push_valid = 1'b1; // RULE_06 RULE_07
          nxt_approx = next_trial;
          if (idx_ff == 3'h0)
            nxt_state = ST_HOLD;
          else
            nxt_idx = idx_ff - 3'h1; // RULE_07
        end
      end
      ST_HOLD:
      begin
        nxt_state = ST_HOLD; // RULE_13
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    // start high ends the frame; a fresh start restarts from msb
    if (!start_low)
      nxt_state = ST_IDLE; // RULE_09 RULE_10
    else if (start_fall && state_ff != ST_IDLE)
    begin
      nxt_state = ST_ARM; // RULE_09
      nxt_approx = bit_mask(3'(`SSAC_MSB_IDX));
      nxt_idx = 3'(`SSAC_MSB_IDX);
      push_valid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_IDLE;
      approximation_register_ff <= '0;
      idx_ff <= 3'h0;
      start_low_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      approximation_register_ff <= nxt_approx;
      idx_ff <= nxt_idx;
      start_low_ff <= start_low;
    end
  end

  // ------------------------------------------------------------
  // bit buffer toward the serial pin
  // ------------------------------------------------------------
  logic pop_valid;
  ssac_bit_t pop_data;
  wire flush = !start_low || (start_fall && state_ff != ST_IDLE);
  ssac_skid u_skid (
    .clk_i(CLK_SYS_I),
    .rst_b_i(rst_b),
    .flush_i(flush),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(1'b1),
    .out_data_o(pop_data)
  );

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_b)
  begin
    if (!rst_b)
    begin
      SDATA_O <= 1'b0;
      SDATA_OE_B_O <= 1'b1;
      TRIAL_CODE_O <= '0;
      RESULT_O <= '0;
      DONE_O <= 1'b0;
    end
    else
    begin
      TRIAL_CODE_O <= nxt_approx;
      SDATA_OE_B_O <= !start_low; // RULE_10
      if (pop_valid && start_low)
        SDATA_O <= pop_data.bit_val; // RULE_01
      DONE_O <= (nxt_state == ST_HOLD);
      // over-range keeps every trial set, giving all ones
      if (nxt_state == ST_HOLD && state_ff == ST_TRIAL)
        RESULT_O <= nxt_approx; // RULE_12
    end
  end

  a_float_when_high: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_10
    !start_low |=> SDATA_OE_B_O)
    else $error("serial output not released while start is high");
  a_msb_first: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_04
    (state_ff == ST_ARM) |-> idx_ff == 3'h5)
    else $error("sequence not armed at the top bit");
  a_arm_on_fall: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_03
    (state_ff == ST_ARM && cclk_fall && start_low && !start_fall) |=> state_ff == ST_TRIAL)
    else $error("first clock fall did not start the trials");
  a_clear_on_high: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_05
    (push_valid && cmp_high) |=> !approximation_register_ff[$past(idx_ff)])
    else $error("trial bit kept although the trial exceeded the input");
  a_keep_on_low: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_05
    (push_valid && !cmp_high) |=> approximation_register_ff[$past(idx_ff)])
    else $error("trial bit cleared although the input reached the trial");
  a_bit_shown: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_07
    (pop_valid && start_low) |=> SDATA_O == $past(pop_data.bit_val))
    else $error("decided bit not shown on the serial output");
  // every fresh start, also one that cuts a running conversion, rearms at the top bit
  a_restart_msb: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_09
    start_fall |=> state_ff == ST_ARM && idx_ff == 3'h5
      && TRIAL_CODE_O == bit_mask(3'(`SSAC_MSB_IDX)))
    else $error("new start did not restart from the top bit");
  a_hold_last: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_13
    (state_ff == ST_HOLD && start_low && !start_fall) |=> state_ff == ST_HOLD)
    else $error("last bit not held while start stays low");
  a_full_scale: assert property (@(posedge CLK_SYS_I) disable iff (!rst_b) // RULE_12
    (state_ff == ST_TRIAL && push_valid && start_low && idx_ff == 3'h0
     && approximation_register_ff == `SSAC_FULL_CODE && !cmp_high)
    |=> RESULT_O == `SSAC_FULL_CODE)
    else $error("over-range input did not give the all-ones code");
endmodule // ssac_top

// [test/ssac_analog_model.sv]
// comparator and analog input as seen by the conversion controller
`timescale 1ns/1ps
module ssac_analog_model
  import ssac_pkg::*;
#(
  parameter int SETTLE_NS = 0
)
(
  input wire logic [5:0] trial_code_i,
  input wire logic [6:0] level_i,
  output logic cmp_high_o
);
  // high when the trial code lies above the input level; a level past 63 is
  // over range, so no trial ever exceeds it and the code saturates
  assign #(SETTLE_NS) cmp_high_o = ({1'b0, trial_code_i} > level_i);
endmodule // ssac_analog_model

// [test/test_serial_sar_adc_control.sv]
// self-checking bench of the serial conversion controller
`timescale 1ns/1ps
module test_serial_sar_adc_control;
  import ssac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic start_b = 1'b1;
  logic conv_clk = 1'b1;
  logic [6:0] level = 7'h00;
  logic cmp_high;
  logic [5:0] trial_code;
  logic [5:0] result;
  logic done;
  logic sdata;
  logic sdata_oe_b;
  int failures = 0;
  int n_compared = 0;

  // ------------------------------------------------------------
  // clock, design and analog side
  // ------------------------------------------------------------
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  ssac_top uut (
    .CLK_SYS_I(clk_sys),
    .RST_B_I(rst_b),
    .START_B_I(start_b),
    .CONV_CLK_I(conv_clk),
    .CMP_HIGH_I(cmp_high),
    .TRIAL_CODE_O(trial_code),
    .RESULT_O(result),
    .DONE_O(done),
    .SDATA_O(sdata),
    .SDATA_OE_B_O(sdata_oe_b)
  );

  ssac_analog_model #(.SETTLE_NS(20)) analog (
    .trial_code_i(trial_code),
    .level_i(level),
    .cmp_high_o(cmp_high)
  );

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one conversion of npulses host clocks, about 347 kHz, start held low
  task automatic convert(input logic [6:0] lvl, input int npulses);
    logic [5:0] code;
    code = (lvl > 7'h3f) ? 6'h3f : lvl[5:0];
    level = lvl;
    start_b = 1'b0;
    wait_cyc(70); // start leads the first fall by more than 500 ns
    check(8'(sdata_oe_b), 8'h00);
    check(8'(trial_code), 8'h20);
    for (int p = 1; p <= npulses; p++)
    begin
      conv_clk = 1'b0;
      wait_cyc(40);
      if (p >= 2 && p <= 7)
      begin
        check(8'(sdata), 8'(code[7-p]));
      end
      wait_cyc(140);
      conv_clk = 1'b1;
      wait_cyc(180);
    end
    if (npulses >= 8)
    begin
      check(8'(done), 8'h01);
      check(8'(result), 8'(code));
      check(8'(sdata), 8'(code[0]));
      check(8'(sdata_oe_b), 8'h00);
    end
    start_b = 1'b1;
    wait_cyc(70); // start stays high beyond 500 ns
    check(8'(sdata_oe_b), 8'h01);
    check(8'(done), 8'h00);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_codes();
    logic [6:0] lvls [4] = '{7'h00, 7'h2a, 7'h15, 7'h3e};
    foreach (lvls[i])
    begin
      convert(lvls[i], 8);
    end
    $display("test_codes done");
  endtask

  task automatic test_over_range();
    convert(7'h50, 8);
    convert(7'h3f, 8);
    $display("test_over_range done");
  endtask

  task automatic test_abort();
    convert(7'h0f, 4);
    convert(7'h31, 9);
    $display("test_abort done");
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: eight conversions of at most 3400 cycles each fit well inside
  initial
  begin
    #600000;
    failures++;
    end_of_test();
  end

  initial
  begin
    wait_cyc(6);
    rst_b = 1'b1;
    wait_cyc(4);
    check(8'(sdata_oe_b), 8'h01);
    test_codes();
    test_over_range();
    test_abort();
    end_of_test();
  end
endmodule // test_serial_sar_adc_control
